// File: verilog/watchdog_regs.svh
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

// counter geometry
`define WD_CNT_W        29
`define WD_SET_W        12
`define WD_LOW_W        17
`define WD_LOW_CONST    17'h00008
// status word layout
`define WD_STAT_W       30
`define WD_STAT_EN_BIT  29
// oscillator and clock figures
`define WD_OSC_KHZ      10000
`define WD_SYS_KHZ      40000
`define WD_DIV_W        2
`define WD_DIV_LAST     2'h3
// reload strobe least width
`define WD_RELOAD_NS    250
`define WD_SYS_NS       25
`define WD_RELOAD_CYC   ((`WD_RELOAD_NS + `WD_SYS_NS - 1) / `WD_SYS_NS)
`define WD_FILT_W       4
`define WD_ZERO29       29'h00000000

`endif

// File: verilog/watchdog_pkg.sv
package watchdog_pkg;
   typedef enum logic [1:0] {
      ST_CONFIG  = 2'b00,
      ST_FACTORY = 2'b01,
      ST_RUN     = 2'b10,
      ST_EXPIRED = 2'b11
   } wd_state_t;
endpackage : watchdog_pkg

// File: verilog/wd_tick_if.sv
`timescale 1ns/1ps
interface wd_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input  tick);
endinterface : wd_tick_if

// File: verilog/wd_osc_divider.sv
`timescale 1ns/1ps
`include "watchdog_regs.svh"
module wd_osc_divider (
   input  wire logic clk_sys_i,
   input  wire logic arst_n_i,
   wd_tick_if.src    tick_bus
);
   logic [`WD_DIV_W-1:0] div_cnt;
   logic                 tick_r;
   wire                  wrap = (div_cnt == `WD_DIV_LAST);

   // one pulse per oscillator period
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_cnt <= '0;
         tick_r  <= 1'b0;
      end else begin
         div_cnt <= wrap ? '0 : div_cnt + 1'b1;
         tick_r  <= wrap;
      end
   end
   assign tick_bus.tick = tick_r;
endmodule : wd_osc_divider

// File: verilog/application_watchdog_timer.sv
// What this block does
// - down-counter starts from factory-loaded timeout setting
// - counter is 29 bits wide
// - start value is setting joined with 17-bit constant
// - decrement on 10 MHz oscillator tick only
// - counting begins once application reaches user mode
// - expiry raises internal timeout indication
// - timeout sets flag then loads factory image
// - inactive throughout configuration cycle
// - always disabled while factory image runs
// - status reports enable bit 29, value below
`timescale 1ns/1ps
`include "watchdog_regs.svh"
module application_watchdog_timer
   import watchdog_pkg::*;
(
   input  wire logic                   clk_sys_i,
   input  wire logic                   arst_n_i,
   input  wire logic [`WD_SET_W-1:0]   timeout_setting_i,
   input  wire logic                   config_done_i,
   input  wire logic                   factory_image_i,
   input  wire logic                   watchdog_reload_n_i,
   input  wire logic                   timeout_flag_clear_i,
   output logic                        timeout_pulse_o,
   output logic                        watchdog_timeout_flag_o,
   output logic                        load_factory_o,
   output logic [`WD_STAT_W-1:0]       app_status_o
);
   wd_tick_if tick_bus ();

   // counter and start value
   logic [`WD_CNT_W-1:0]   count;
   logic [`WD_CNT_W-1:0]   start_value;

   // synchroniser stages
   logic                   reload_s1;
   logic                   reload_s2;
   logic                   done_s1;
   logic                   done_s2;
   logic                   fact_s1;
   logic                   fact_s2;

   // reload strobe width filter
   logic [`WD_FILT_W-1:0]  low_cnt;
   logic                   reload_seen;

   // mode state
   wd_state_t              state;
   wd_state_t              next_state;

   // oscillator tick from the system clock
   wd_osc_divider u_div (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .tick_bus  (tick_bus.src)
   );

   // oscillator tick, one cycle per period
   wire tick = tick_bus.tick;

   // reload strobe synchroniser, idles high
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reload_s1 <= 1'b1;
         reload_s2 <= 1'b1;
      end else begin
         reload_s1 <= watchdog_reload_n_i;
         reload_s2 <= reload_s1;
      end
   end

   // configuration done synchroniser
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
      end else begin
         done_s1 <= config_done_i;
         done_s2 <= done_s1;
      end
   end

   // factory image synchroniser
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fact_s1 <= 1'b0;
         fact_s2 <= 1'b0;
      end else begin
         fact_s1 <= factory_image_i;
         fact_s2 <= fact_s1;
      end
   end

   // accept on the last cycle of the least strobe width
   wire low_long = (low_cnt >= `WD_FILT_W'(`WD_RELOAD_CYC - 1));
   wire accept   = !reload_s2 && low_long && !reload_seen;

   // count low cycles; one accept per low phase
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_cnt     <= '0;
         reload_seen <= 1'b0;
      end else if (reload_s2) begin
         low_cnt     <= '0;
         reload_seen <= 1'b0;
      end else begin
         if (!low_long) begin
            low_cnt <= low_cnt + 1'b1;
         end
         if (accept) begin
            reload_seen <= 1'b1;
         end
      end
   end

   // start value: 12 set bits over fixed low constant
   assign start_value = {timeout_setting_i, `WD_LOW_CONST};

   // mode decode; a reload in the expiry cycle wins
   wire user_app = done_s2 && !fact_s2;
   wire at_zero  = (count == `WD_ZERO29);
   wire run      = (state == ST_RUN);
   wire expire   = run && tick && at_zero && !accept;

   // next state
   always_comb begin
      next_state = state;
      case (state)
         ST_CONFIG: begin
            if (done_s2) begin
               next_state = fact_s2 ? ST_FACTORY : ST_RUN;
            end
         end
         ST_FACTORY: begin
            if (!done_s2) begin
               next_state = ST_CONFIG;
            end
         end
         ST_RUN: begin
            if (!user_app) begin
               next_state = ST_CONFIG;
            end else if (expire) begin
               next_state = ST_EXPIRED;
            end
         end
         ST_EXPIRED: begin
            if (fact_s2 || !done_s2) begin
               next_state = ST_CONFIG;
            end
         end
         default: begin
            next_state = ST_CONFIG;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= ST_CONFIG;
      end else begin
         state <= next_state;
      end
   end

   // counter: load outside run or on reload, decrement on tick
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count <= '0;
      end else if (!run) begin
         count <= start_value;
      end else if (accept) begin
         count <= start_value;
      end else if (tick && !at_zero) begin
         count <= count - 1'b1;
      end
   end

   // one-cycle expiry pulse
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timeout_pulse_o <= 1'b0;
      end else begin
         timeout_pulse_o <= expire;
      end
   end

   // sticky timeout flag: set beats clear
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         watchdog_timeout_flag_o <= 1'b0;
      end else if (expire) begin
         watchdog_timeout_flag_o <= 1'b1;
      end else if (timeout_flag_clear_i) begin
         watchdog_timeout_flag_o <= 1'b0;
      end
   end

   // factory reload request while expired
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         load_factory_o <= 1'b0;
      end else begin
         load_factory_o <= (state == ST_EXPIRED);
      end
   end

   // status word: enable bit and full timeout value
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         app_status_o <= '0;
      end else begin
         app_status_o <= {run, start_value};
      end
   end
endmodule : application_watchdog_timer

// File: tb/wd_user_model.sv
`timescale 1ns/1ps
module wd_user_model (
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic [4:0] len_i,
   output logic            reload_n_o
);
   logic [4:0] left = 5'h00;
   // count down the low phase of the strobe
   always @(posedge clk_i) begin
      if (go_i) begin
         left <= len_i;
      end else if (left != 5'h00) begin
         left <= left - 5'h01;
      end
   end
   assign reload_n_o = (left == 5'h00);
endmodule : wd_user_model

// File: tb/wd_chk.sv
`timescale 1ns/1ps
`include "watchdog_regs.svh"
module wd_chk (
   input wire logic        clk_sys_i, arst_n_i,
   input wire logic [11:0] timeout_setting_i,
   input wire logic        config_done_i, factory_image_i, watchdog_reload_n_i,
   input wire logic        timeout_flag_clear_i, timeout_pulse_o,
   input wire logic        watchdog_timeout_flag_o, load_factory_o,
   input wire logic [29:0] app_status_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   // expiry then factory request
   sequence expire_s;
      timeout_pulse_o ##1 load_factory_o;
   endsequence
   pulse_flag_a: assert property (timeout_pulse_o |-> watchdog_timeout_flag_o)
      else $error("pulse no flag");
   expire_load_a: assert property (timeout_pulse_o |-> expire_s)
      else $error("no load");
   pulse_single_a: assert property (timeout_pulse_o |=> !timeout_pulse_o)
      else $error("long pulse");
   status_value_a: assert property (app_status_o[29] |->
      app_status_o[28:0] == {timeout_setting_i, `WD_LOW_CONST}) else $error("bad value");
   factory_off_a: assert property (factory_image_i [*6] |-> !app_status_o[29])
      else $error("on in factory");
   config_off_a: assert property (!config_done_i [*6] |-> !app_status_o[29])
      else $error("on in config");
   pulse_run_a: assert property (timeout_pulse_o |-> $past(app_status_o[29]))
      else $error("idle expiry");
   load_idle_a: assert property (load_factory_o |-> !app_status_o[29])
      else $error("load while on");
endmodule : wd_chk
bind application_watchdog_timer wd_chk chk (.clk_sys_i, .arst_n_i, .timeout_setting_i,
   .config_done_i, .factory_image_i, .watchdog_reload_n_i, .timeout_flag_clear_i,
   .timeout_pulse_o, .watchdog_timeout_flag_o, .load_factory_o, .app_status_o);

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic        clk_sys_i = 1'b0, arst_n_i = 1'b0, config_done_i = 1'b0;
   logic        factory_image_i = 1'b0, timeout_flag_clear_i = 1'b0, go = 1'b0;
   logic [11:0] timeout_setting_i = 12'hA5C;
   logic [4:0]  len = 5'h00;
   logic        watchdog_reload_n_i, timeout_pulse_o, watchdog_timeout_flag_o, load_factory_o;
   logic [29:0] app_status_o;
   int          fails = 0, num_checks = 0, cyc = 0;
   always #12.5 clk_sys_i = ~clk_sys_i;
   application_watchdog_timer dut (.clk_sys_i, .arst_n_i, .timeout_setting_i, .config_done_i,
      .factory_image_i, .watchdog_reload_n_i, .timeout_flag_clear_i, .timeout_pulse_o,
      .watchdog_timeout_flag_o, .load_factory_o, .app_status_o);
   wd_user_model user (.clk_i(clk_sys_i), .go_i(go), .len_i(len), .reload_n_o(watchdog_reload_n_i));
   task automatic chk(string what, logic [29:0] seen, logic [29:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic step(int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : step
   task automatic strobe(logic [4:0] n);
      len = n;
      go = 1'b1;
      step(1);
      go = 1'b0;
   endtask : strobe
   // enable only in application user mode
   task automatic t_modes;
      factory_image_i = 1'b1;
      config_done_i = 1'b1;
      step(8);
      chk("factory en", 30'(app_status_o[29]), 30'h0);
      factory_image_i = 1'b0;
      config_done_i = 1'b0;
      step(8);
      chk("config en", 30'(app_status_o[29]), 30'h0);
      config_done_i = 1'b1;
      step(8);
      chk("status", app_status_o, {1'b1, 12'hA5C, 17'h00008});
      config_done_i = 1'b0;
      step(8);
      chk("config off", 30'(app_status_o[29]), 30'h0);
      $display("t_modes done");
   endtask : t_modes
   // reload, ignored short strobe, expiry and clear
   task automatic t_expire;
      int n;
      timeout_setting_i = 12'h000;
      step(4);
      config_done_i = 1'b1;
      step(10);
      strobe(5'h0A);
      step(30);
      chk("early flag", 30'(watchdog_timeout_flag_o), 30'h0);
      strobe(5'h09);
      for (n = 0; n < 40 && timeout_pulse_o !== 1'b1; n++) step(1);
      chk("pulse", {watchdog_timeout_flag_o, timeout_pulse_o}, 30'h3);
      step(1);
      chk("load", {load_factory_o, app_status_o[29]}, 30'h2);
      factory_image_i = 1'b1;
      timeout_flag_clear_i = 1'b1;
      step(1);
      timeout_flag_clear_i = 1'b0;
      step(6);
      chk("cleared", {watchdog_timeout_flag_o, load_factory_o}, 30'h0);
      $display("t_expire done");
   endtask : t_expire
   initial begin
      step(3);
      arst_n_i = 1'b1;
      step(2);
      t_modes();
      t_expire();
      results();
   end
   // hang guard
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         results();
      end
   end
endmodule : tb
